// *** src/aon_block_defines.vh ***
`ifndef AON_BLOCK_DEFINES_VH
`define AON_BLOCK_DEFINES_VH

// ************************************************
// register byte offsets
// ************************************************
`define OFF_RESET_CONTROL   12'h570
`define OFF_RESET_CAUSE     12'h574
`define OFF_POWER_LOCKS     12'h594
`define OFF_AON_COUNT       12'h700
`define OFF_AON_ENABLE      12'h704
`define OFF_PT_VALUE        12'h708
`define OFF_PT_STATUS       12'h70C
`define OFF_PT_CONTROL      12'h710
`define OFF_PT_SETTING      12'h714
`define OFF_IRQ_STATUS      12'h718
`define OFF_IRQ_MASK        12'h71C

// ************************************************
// field positions
// ************************************************
`define BIT_BUS_ERROR       5
`define BIT_HALT_WRST       3
`define BIT_WDOG_WRST       1
`define BIT_SW_CAUSE        0
`define BIT_WAKE_LOCK       17
`define BIT_STROBE_LOCK     16
`define BIT_RUN             0
`define BIT_PT_STATUS       0
`define BIT_PT_RELOAD       1
`define BIT_PT_CLEAR        0
`define BIT_WARM_REQ        1
`define BIT_IRQ_ALARM       0
`define BIT_IRQ_CAUSE       1

// ************************************************
// reset values and constants
// ************************************************
`define RST_RUN             1'h1
`define RST_PT_STATUS       1'h1
`define RST_WORD            32'h00000000
`define COUNT_STEP          32'h00000001
`define WAKE_MASK_RST       32'h00000000
`define STROBE_DELAY_RST    8'h0F
`define IRQ_BITS            2

`endif

// *** src/sticky_flag.v ***
// ************************************************
// sticky event flag, set wins over clear
// ************************************************
module sticky_flag
(
  // clock and reset
  input  wire clock_in,
  input  wire rst_in,
  // event and clear
  input  wire set_in,
  input  wire clear_in,
  // state
  output reg  flag_out
);

  // set has priority so a same-cycle event is never lost
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clear_in)
      flag_out <= 1'b0;
  end

endmodule

// *** src/reset_status_and_aon_timers.v ***
// Register access over APB is this design's own decision.
`include "aon_block_defines.vh"

module reset_status_and_aon_timers
(
  // clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        power_rst_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // reset cause events, asynchronous pins
  input  wire        bus_error_in,
  input  wire        halt_warm_reset_in,
  input  wire        watchdog_warm_reset_in,
  input  wire        warm_reset_done_in,
  // outputs to system control
  output reg         warm_reset_request_out,
  output reg         periodic_alarm_out,
  output reg         irq_out,
  output reg  [31:0] wake_mask_out,
  output reg  [7:0]  strobe_delay_out
);

  // ************************************************
  // input synchronisers
  // ************************************************
  reg  [3:0] sync_a;          // first stage, read only by sync_b
  reg  [3:0] sync_b;          // second stage
  reg  [3:0] sync_prev;       // for rising edge detect

  // two flops for each asynchronous event pin
  // a pin still high when warm reset lifts reads as a fresh rise;
  // the event sources are expected to drop their levels by then
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_a    <= 4'h0;
      sync_b    <= 4'h0;
      sync_prev <= 4'h0;
    end
    else
    begin
      sync_a    <= {warm_reset_done_in, watchdog_warm_reset_in,
                    halt_warm_reset_in, bus_error_in};
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  wire [3:0] event_rise = sync_b & ~sync_prev;   // one-cycle events

  // ************************************************
  // apb decode
  // ************************************************
  wire bus_setup  = psel_in & ~penable_in;       // setup phase
  wire bus_access = psel_in & penable_in;         // access phase
  wire write_hit  = bus_access & pwrite_in & pready_out;
  wire known_addr = (paddr_in == `OFF_RESET_CONTROL) |
                    (paddr_in == `OFF_RESET_CAUSE)   |
                    (paddr_in == `OFF_POWER_LOCKS)   |
                    (paddr_in == `OFF_AON_COUNT)     |
                    (paddr_in == `OFF_AON_ENABLE)    |
                    (paddr_in == `OFF_PT_VALUE)      |
                    (paddr_in == `OFF_PT_STATUS)     |
                    (paddr_in == `OFF_PT_CONTROL)    |
                    (paddr_in == `OFF_PT_SETTING)    |
                    (paddr_in == `OFF_IRQ_STATUS)    |
                    (paddr_in == `OFF_IRQ_MASK);

  // per-register write strobes
  wire wr_ctrl   = write_hit & (paddr_in == `OFF_RESET_CONTROL);
  wire wr_cause  = write_hit & (paddr_in == `OFF_RESET_CAUSE);
  wire wr_locks  = write_hit & (paddr_in == `OFF_POWER_LOCKS);
  wire wr_enable = write_hit & (paddr_in == `OFF_AON_ENABLE);
  wire wr_ptctl  = write_hit & (paddr_in == `OFF_PT_CONTROL);
  wire wr_set    = write_hit & (paddr_in == `OFF_PT_SETTING);
  wire wr_irqst  = write_hit & (paddr_in == `OFF_IRQ_STATUS);
  wire wr_mask   = write_hit & (paddr_in == `OFF_IRQ_MASK);

  // ************************************************
  // reset cause flags
  // ************************************************
  // the flags sit in the power domain: a warm reset must not
  // wipe the record of what caused it, so of the two resets
  // only power_rst_in clears them; a write of ones also clears them
  wire bus_error_flag;        // bit 5
  wire halt_flag;             // bit 3
  wire watchdog_flag;         // bit 1
  wire software_flag;         // bit 0

  // sw flag: warm reset completing while a request was pending
  wire sw_reset_event = event_rise[3] & warm_reset_request_out;

  // error response seen on the processor bus
  sticky_flag u_bus_error
  (
    .clock_in (clock_in),
    .rst_in   (power_rst_in),
    .set_in   (event_rise[0]),
    .clear_in (wr_cause & pwdata_in[`BIT_BUS_ERROR]),
    .flag_out (bus_error_flag)
  );

  // enabled halt interrupt caused the warm reset
  sticky_flag u_halt
  (
    .clock_in (clock_in),
    .rst_in   (power_rst_in),
    .set_in   (event_rise[1]),
    .clear_in (wr_cause & pwdata_in[`BIT_HALT_WRST]),
    .flag_out (halt_flag)
  );

  // peripheral watchdog caused the warm reset
  sticky_flag u_watchdog
  (
    .clock_in (clock_in),
    .rst_in   (power_rst_in),
    .set_in   (event_rise[2]),
    .clear_in (wr_cause & pwdata_in[`BIT_WDOG_WRST]),
    .flag_out (watchdog_flag)
  );

  // software request caused the warm reset
  sticky_flag u_software
  (
    .clock_in (clock_in),
    .rst_in   (power_rst_in),
    .set_in   (sw_reset_event),
    .clear_in (wr_cause & pwdata_in[`BIT_SW_CAUSE]),
    .flag_out (software_flag)
  );

  // reserved bits tie low, all flags reset to zero
  wire [31:0] cause_word = {26'h0000000, bus_error_flag, 1'b0,
                            halt_flag, 1'b0, watchdog_flag,
                            software_flag};

  // ************************************************
  // warm reset request
  // ************************************************
  // held until the reset logic reports the reset took place
  // a write of zero never drops it: software cannot cancel a
  // warm reset once it has been asked for
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      warm_reset_request_out <= 1'b0;
    else if (wr_ctrl & pwdata_in[`BIT_WARM_REQ])
      warm_reset_request_out <= 1'b1;
    else if (event_rise[3])
      warm_reset_request_out <= 1'b0;
  end

  // ************************************************
  // power setting locks, power-domain reset only
  // ************************************************
  reg wake_lock;              // bit 17
  reg strobe_lock;            // bit 16

  // set-only; warm reset does not touch them
  always @(posedge clock_in or posedge power_rst_in)
  begin
    if (power_rst_in)
    begin
      wake_lock        <= 1'b0;
      strobe_lock      <= 1'b0;
      wake_mask_out    <= `WAKE_MASK_RST;
      strobe_delay_out <= `STROBE_DELAY_RST;
    end
    else
    begin
      if (wr_locks & pwdata_in[`BIT_WAKE_LOCK])
        wake_lock <= 1'b1;
      if (wr_locks & pwdata_in[`BIT_STROBE_LOCK])
        strobe_lock <= 1'b1;
      // wake mask written through the lock register's data port only
      // while unlocked, by writes with lock bits clear; strobe delay
      // written through the irq mask register's bits 15:8 while unlocked
      if (wr_locks & ~wake_lock & ~pwdata_in[`BIT_WAKE_LOCK] &
          ~pwdata_in[`BIT_STROBE_LOCK])
        wake_mask_out <= pwdata_in;
      if (wr_mask & ~strobe_lock)
        strobe_delay_out <= pwdata_in[15:8];
    end
  end

  // ************************************************
  // always-on counter, power-domain state
  // ************************************************
  reg [31:0] aon_count;       // free-running value
  reg        aon_run;         // enable bit

  // kept across warm reset: only the power reset clears it
  always @(posedge clock_in or posedge power_rst_in)
  begin
    if (power_rst_in)
    begin
      aon_count <= `RST_WORD;
      aon_run   <= `RST_RUN;
    end
    else
    begin
      if (wr_enable)
        aon_run <= pwdata_in[`BIT_RUN];
      if (aon_run)
        aon_count <= aon_count + `COUNT_STEP;
    end
  end

  // ************************************************
  // periodic down-counter
  // ************************************************
  reg [31:0] pt_value;        // current count
  reg [31:0] pt_setting;      // time-out setting
  reg        pt_status;       // alarm status

  wire pt_reload = wr_ptctl & pwdata_in[`BIT_PT_RELOAD];
  wire pt_clear  = wr_ptctl & pwdata_in[`BIT_PT_CLEAR];
  wire pt_active = (pt_setting != `RST_WORD);
  wire pt_wrap   = pt_active & (pt_value == `RST_WORD);

  // count down, alarm at zero, reload; a same-cycle wrap beats a
  // clear write only while the status is already clear
  // the alarm level follows the status bit but stays low after a
  // power reset, since no wrap has happened yet
  always @(posedge clock_in or posedge power_rst_in)
  begin
    if (power_rst_in)
    begin
      pt_value           <= `RST_WORD;
      pt_setting         <= `RST_WORD;
      pt_status          <= `RST_PT_STATUS;
      periodic_alarm_out <= 1'b0;
    end
    else
    begin
      if (wr_set)
        pt_setting <= pwdata_in;
      if (pt_reload)
        pt_value <= pt_setting;
      else if (pt_wrap)
        pt_value <= pt_setting;
      else if (pt_active)
        pt_value <= pt_value - `COUNT_STEP;
      // alarm only fires while status is clear
      if (pt_wrap & ~pt_status)
      begin
        pt_status          <= 1'b1;
        periodic_alarm_out <= 1'b1;
      end
      else if (pt_clear)
      begin
        pt_status          <= 1'b0;
        periodic_alarm_out <= 1'b0;
      end
    end
  end

  // ************************************************
  // interrupt status and mask
  // ************************************************
  reg [1:0] irq_status;       // 0 alarm, 1 any reset cause
  reg [1:0] irq_mask;         // 1 enables the source

  wire [1:0] irq_set = {event_rise[0] | event_rise[1] | event_rise[2] |
                        sw_reset_event, pt_wrap & ~pt_status};

  // write one clears, a new event wins
  // irq_out is registered, so it trails the status by one clock
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      irq_out    <= 1'b0;
    end
    else
    begin
      irq_status <= irq_set |
                    (irq_status & ~({2{wr_irqst}} & pwdata_in[1:0]));
      if (wr_mask)
        irq_mask <= pwdata_in[1:0];
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // ************************************************
  // apb read and response
  // ************************************************
  reg [31:0] next_rdata;      // read mux

  // read mux; reserved bits read zero
  always @*
  begin
    next_rdata = `RST_WORD;
    case (paddr_in)
      `OFF_RESET_CONTROL: next_rdata = {30'h0,
                                        warm_reset_request_out, 1'b0};
      `OFF_RESET_CAUSE:   next_rdata = cause_word;
      `OFF_POWER_LOCKS:   next_rdata = {14'h0, wake_lock, strobe_lock,
                                        16'h0};
      `OFF_AON_COUNT:     next_rdata = aon_count;
      `OFF_AON_ENABLE:    next_rdata = {31'h0, aon_run};
      `OFF_PT_VALUE:      next_rdata = pt_value;
      `OFF_PT_STATUS:     next_rdata = {31'h0, pt_status};
      `OFF_PT_CONTROL:    next_rdata = `RST_WORD;
      `OFF_PT_SETTING:    next_rdata = pt_setting;
      `OFF_IRQ_STATUS:    next_rdata = {30'h0, irq_status};
      `OFF_IRQ_MASK:      next_rdata = {30'h0, irq_mask};
      default:            next_rdata = `RST_WORD;
    endcase
  end

  // no wait states: ready in the first access cycle after setup
  // read data is registered at setup so the mux never reaches the
  // pin; the cost is that a read shows the value one edge old
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      prdata_out  <= `RST_WORD;
      pslverr_out <= 1'b0;
    end
    else if (bus_setup)
    begin
      pready_out  <= 1'b1;
      prdata_out  <= pwrite_in ? `RST_WORD : next_rdata;
      pslverr_out <= ~known_addr;
    end
    else
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule

// *** verif/reset_status_and_aon_timers_assertions.sv ***
module reset_status_and_aon_timers_assertions
(
  // clock and resets
  input wire        clock_in,
  input wire        rst_in,
  input wire        power_rst_in,
  // apb
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  // events and outputs
  input wire        bus_error_in,
  input wire        halt_warm_reset_in,
  input wire        watchdog_warm_reset_in,
  input wire        warm_reset_done_in,
  input wire        warm_reset_request_out,
  input wire        periodic_alarm_out,
  input wire        irq_out,
  input wire [31:0] wake_mask_out,
  input wire [7:0]  strobe_delay_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus phase decode
  wire setup  = psel_in && !penable_in;
  wire acc    = psel_in && penable_in && pready_out && pwrite_in;
  wire hit    = paddr_in inside {12'h570, 12'h574, 12'h594, 12'h700,
    12'h704, 12'h708, 12'h70C, 12'h710, 12'h714, 12'h718, 12'h71C};
  wire req_wr = acc && paddr_in == 12'h570 && pwdata_in[1];
  wire clr_wr = acc && paddr_in == 12'h710 && pwdata_in[0];

  // ************************************************
  // properties
  // ************************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in || power_rst_in);

  AST_READY_NEXT: assert property (setup |=> pready_out)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  AST_ERR_MAP: assert property (setup |=> pslverr_out == !$past(hit))
    else $error("error flag does not match address map");
  AST_ERR_READ_ZERO: assert property
    (pready_out && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
    else $error("refused read returned data");
  AST_WARM_SET: assert property (req_wr |=> warm_reset_request_out)
    else $error("warm request not raised");
  AST_WARM_CAUSE: assert property
    ($rose(warm_reset_request_out) |-> $past(req_wr))
    else $error("warm request raised without write");
  AST_WARM_DROP: assert property
    ($rose(warm_reset_done_in) |-> ##[1:4] !warm_reset_request_out)
    else $error("warm request did not clear");
  AST_ALARM_HOLD: assert property
    (periodic_alarm_out && !clr_wr |=> periodic_alarm_out)
    else $error("alarm dropped without clear");
  // with the alarm up no wrap can raise it again, so the clear wins
  AST_ALARM_CLEAR: assert property
    (clr_wr && periodic_alarm_out |=> !periodic_alarm_out)
    else $error("alarm clear ignored");

  // main scenarios reached
  cover property (req_wr);
  cover property ($rose(periodic_alarm_out));
  cover property (setup && !hit);
endmodule

bind reset_status_and_aon_timers
  reset_status_and_aon_timers_assertions checker_i (.*);

// *** verif/reset_status_and_aon_timers_tb_top.sv ***
module reset_status_and_aon_timers_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // driven by the bench
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        power_rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  ev = 4'h0;      // done, watchdog, halt, bus error
  // seen from the design
  wire  [31:0] prdata_out;
  wire         pready_out;
  wire         pslverr_out;
  wire         bus_error_in;
  wire         halt_warm_reset_in;
  wire         watchdog_warm_reset_in;
  wire         warm_reset_done_in;
  wire         warm_reset_request_out;
  wire         periodic_alarm_out;
  wire         irq_out;
  wire  [31:0] wake_mask_out;
  wire  [7:0]  strobe_delay_out;
  // bookkeeping
  integer      err_count = 0;
  integer      samples_checked = 0;
  integer      i;
  logic [31:0] rd;
  logic [31:0] v;
  logic        rs;

  assign {warm_reset_done_in, watchdog_warm_reset_in, halt_warm_reset_in,
    bus_error_in} = ev;

  reset_status_and_aon_timers reset_status_and_aon_timers_i (.*);

  always #2.5 clock_in = ~clock_in;

  // ************************************************
  // helpers
  // ************************************************
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until ready is sampled high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_in);
      n = n + 1;
    end
    while (pready_out !== 1'b1 && n < 20);
    if (n == 20)
    begin
      chk(32'h0, 32'h1);
      end_of_test;
    end
    rd = prdata_out;
    rs = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // event pin held long enough to pass the synchroniser
  task pulse(input integer k);
    ev[k] <= 1'b1;
    repeat (2) @(posedge clock_in);
    ev[k] <= 1'b0;
    repeat (4) @(posedge clock_in);
  endtask

  task kick(input logic p);
    if (p)
      power_rst_in <= 1'b1;
    else
      rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    power_rst_in <= 1'b0;
    rst_in <= 1'b0;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    // both resets held for three clocks, released on an edge
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    power_rst_in <= 1'b0;
    rdc(12'h574, 32'h0);
    chk(32'(rs), 32'h0);
    rdc(12'h594, 32'h0);
    rdc(12'h704, 32'h1);
    rdc(12'h708, 32'h0);
    rdc(12'h70C, 32'h1);
    rdc(12'h710, 32'h0);
    // unmapped place refused both ways
    rdc(12'h7F0, 32'h0);
    chk(32'(rs), 32'h1);
    wr(12'h7F0, 32'hFFFFFFFF);
    chk(32'(rs), 32'h1);
    // counter steps once per clock, holds when stopped and over warm reset
    xfer(1'b0, 12'h700, 32'h0);
    v = rd;
    rdc(12'h700, v + 32'h3);
    wr(12'h704, 32'h0);
    xfer(1'b0, 12'h700, 32'h0);
    v = rd;
    rdc(12'h700, v);
    kick(1'b0);
    rdc(12'h700, v);
    wr(12'h704, 32'h1);
    // cause flags with interrupt unmasked
    wr(12'h71C, 32'h2);
    for (i = 0; i < 3; i++)
    begin
      pulse(i);
      chk(32'(irq_out), 32'h1);
      rdc(12'h574, 32'h20 >> (2 * i));
      wr(12'h574, 32'h20 >> (2 * i));
      wr(12'h718, 32'h2);
      rdc(12'h574, 32'h0);
      chk(32'(irq_out), 32'h0);
    end
    // masked event stays pending, shows once unmasked
    wr(12'h71C, 32'h0);
    pulse(0);
    chk(32'(irq_out), 32'h0);
    wr(12'h71C, 32'h2);
    repeat (2) @(posedge clock_in);
    chk(32'(irq_out), 32'h1);
    wr(12'h574, 32'h20);
    // halt flag must outlive a warm reset
    pulse(1);
    kick(1'b0);
    rdc(12'h574, 32'h8);
    wr(12'h574, 32'h8);
    // software warm reset request and its flag
    wr(12'h570, 32'h2);
    @(posedge clock_in);
    chk(32'(warm_reset_request_out), 32'h1);
    pulse(3);
    chk(32'(warm_reset_request_out), 32'h0);
    rdc(12'h574, 32'h1);
    wr(12'h574, 32'h1);
    rdc(12'h574, 32'h0);
    // set-only locks freeze settings until power reset
    wr(12'h71C, 32'h3300);
    wr(12'h594, 32'hA5);
    wr(12'h594, 32'h30000);
    wr(12'h594, 32'h0);
    rdc(12'h594, 32'h30000);
    wr(12'h594, 32'h5A);
    wr(12'h71C, 32'h4400);
    @(posedge clock_in);
    chk(wake_mask_out, 32'hA5);
    chk(32'(strobe_delay_out), 32'h33);
    kick(1'b1);
    rdc(12'h594, 32'h0);
    chk(wake_mask_out, 32'h0);
    chk(32'(strobe_delay_out), 32'h0F);
    // periodic timer: clear status, wait for the wrap
    wr(12'h714, 32'h28);
    wr(12'h710, 32'h1);
    rdc(12'h70C, 32'h0);
    i = 0;
    while (periodic_alarm_out !== 1'b1 && i < 200)
    begin
      @(posedge clock_in);
      i++;
    end
    chk(32'(periodic_alarm_out), 32'h1);
    if (i == 200)
      end_of_test;
    rdc(12'h70C, 32'h1);
    xfer(1'b0, 12'h708, 32'h0);
    chk(32'(rd <= 32'h28), 32'h1);
    repeat (90) @(posedge clock_in);
    rdc(12'h70C, 32'h1);
    // reload jumps to the new setting
    wr(12'h714, 32'h3E8);
    wr(12'h710, 32'h2);
    xfer(1'b0, 12'h708, 32'h0);
    chk(32'(rd >= 32'h3DE && rd <= 32'h3E8), 32'h1);
    rdc(12'h710, 32'h0);
    wr(12'h710, 32'h1);
    @(posedge clock_in);
    chk(32'(periodic_alarm_out), 32'h0);
    rdc(12'h70C, 32'h0);
    // zero setting stops the timer
    wr(12'h714, 32'h0);
    xfer(1'b0, 12'h708, 32'h0);
    v = rd;
    rdc(12'h708, v);
    end_of_test;
  end
endmodule
